// [pkg/ipcp_pkg.sv]
/*
  Constants, register map and state type of the image payload checksum
  packetizer. Assumes a 10 MHz system clock and a 32-bit classic
  Wishbone register bus.
*/
package ipcp_pkg;

  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam int          ADR_W      = 8;
  localparam logic [7:0]  REG_MODE   = 8'h00;
  localparam logic [7:0]  REG_PICK   = 8'h04;
  localparam logic [7:0]  REG_SWITCH = 8'h08;
  localparam logic [7:0]  REG_BPC    = 8'h0C;
  localparam logic [7:0]  REG_STAT   = 8'h10;

  // ==========================================================
  // fields and reset values
  localparam int          MODE_BIT     = 0;
  localparam int          SWITCH_BIT   = 0;
  localparam int          PICK_W       = 4;
  localparam logic [3:0]  PICK_RST     = 4'h0;
  localparam logic [3:0]  CHECKSUM_CHOICE = 4'h1;
  localparam int          BPC_W        = 14;
  localparam logic [13:0] BPC_MIN      = 14'h0001;
  localparam logic [13:0] BPC_MAX      = 14'h2000;
  localparam logic [13:0] BPC_RST      = 14'h2000;
  localparam int          STAT_ACT_BIT = 16;
  localparam int          STAT_REJ_BIT = 17;

  // ==========================================================
  // checksum
  localparam int          CRC_W    = 16;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // ==========================================================
  // timing: bus cycle and the least spacing kept between ticks
  localparam int          CLK_NS     = 100;
  localparam int          CYCLE_NS   = 125000;
  localparam int          CYCLE_CLKS = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          GAP_W      = 11;
  localparam logic [10:0] GUARD_CLKS = 11'(CYCLE_CLKS / 2);

  // ==========================================================
  // buffering
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W     = 9;

  typedef enum logic [2:0] {
    ST_IDLE, ST_IMG, ST_TRL, ST_CRC_HI, ST_CRC_LO
  } ipcp_asm_e;

endpackage : ipcp_pkg

// [hw/ipcp_packetizer.sv]
/*
  Payload assembler with checksum trailer, byte FIFO and per-cycle
  packet divider. Assumes pixel and trailer streams on MCLK, a bus
  cycle start pulse arriving asynchronously on a pin, and a link
  sink that takes one byte per cycle while ready.
*/
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

// ============================================================
// byte fifo
module ipcp_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : ipcp_fifo

// ============================================================
// top
// What this block does
// - The checksum covers all image bytes and every other trailer, never itself.
// - The checksum trailer is always the last item of the payload.
// - The checksum trailer cannot be enabled while trailer mode is off.
// - Switching trailer mode off disables every trailer including the checksum.
// - With the checksum chosen and switched on, every image gets one checksum trailer.
// - Each bus cycle tick arms one packet start; a tick on the clock of a start keeps it armed for a second.
// - A packet size outside one byte to the bus maximum is refused.
// - Each packet carries the configured number of bytes, except a packet that ends an image, which stops at the image end.
// - The packet size is rounded down to a multiple of four bytes; sizes one to three are kept as written.
module ipcp_packetizer (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        PIX_VALID,
  output logic             PIX_READY,
  input  wire logic [7:0]  PIX_DATA,
  input  wire logic        PIX_LAST,
  input  wire logic        TRL_PRESENT,
  input  wire logic        TRL_VALID,
  output logic             TRL_READY,
  input  wire logic [7:0]  TRL_DATA,
  input  wire logic        TRL_LAST,
  input  wire logic        CYCLE_START,
  output logic             PKT_VALID,
  input  wire logic        PKT_READY,
  output logic      [7:0]  PKT_DATA,
  output logic             PKT_LAST,
  output logic             PKT_IMG_END
);

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ ipcp_pkg::CRC_POLY)
                         : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_byte

  // ==========================================================
  // register file
  logic                            payload_trailer_mode_on;
  logic [ipcp_pkg::PICK_W-1:0]     trailer_picker;
  logic                            crc_en;
  logic [ipcp_pkg::BPC_W-1:0]      bytes_per_cycle;
  logic                            bpc_reject;
  logic [15:0]                     crc;
  ipcp_pkg::ipcp_asm_e             st;
  ipcp_pkg::ipcp_asm_e             next_st;

  wire wb_req = WB_CYC_I & WB_STB_I;
  wire wr_now = wb_req & WB_ACK_O & WB_WE_I;
  wire wr_mode = wr_now & (WB_ADR_I == ipcp_pkg::REG_MODE) & WB_SEL_I[0];
  wire wr_pick = wr_now & (WB_ADR_I == ipcp_pkg::REG_PICK) & WB_SEL_I[0];
  wire wr_sw   = wr_now & (WB_ADR_I == ipcp_pkg::REG_SWITCH) & WB_SEL_I[0];
  wire wr_bpc  = wr_now & (WB_ADR_I == ipcp_pkg::REG_BPC)
                 & (&WB_SEL_I[1:0]);
  wire crc_picked = (trailer_picker == ipcp_pkg::CHECKSUM_CHOICE);

  wire [ipcp_pkg::BPC_W-1:0] bpc_in = WB_DAT_I[ipcp_pkg::BPC_W-1:0];
  wire bpc_upper = |WB_DAT_I[31:ipcp_pkg::BPC_W];
  wire bpc_ok = ~bpc_upper & (bpc_in >= ipcp_pkg::BPC_MIN)
                & (bpc_in <= ipcp_pkg::BPC_MAX);
  // sizes below four are kept as written so one byte stays legal
  wire [ipcp_pkg::BPC_W-1:0] bpc_round = (|bpc_in[ipcp_pkg::BPC_W-1:2])
    ? {bpc_in[ipcp_pkg::BPC_W-1:2], 2'b00} : bpc_in;

  wire mode_off_wr = wr_mode & ~WB_DAT_I[ipcp_pkg::MODE_BIT];
  wire [31:0] rd_mux =
    (WB_ADR_I == ipcp_pkg::REG_MODE)   ? {31'h0, payload_trailer_mode_on} :
    (WB_ADR_I == ipcp_pkg::REG_PICK)   ? {28'h0, trailer_picker} :
    (WB_ADR_I == ipcp_pkg::REG_SWITCH) ? {31'h0, crc_picked & crc_en} :
    (WB_ADR_I == ipcp_pkg::REG_BPC)    ? {18'h0, bytes_per_cycle} :
    (WB_ADR_I == ipcp_pkg::REG_STAT)   ?
      {14'h0, bpc_reject, st != ipcp_pkg::ST_IDLE, crc} : 32'h0;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= wb_req & ~WB_ACK_O;
      if (wb_req & ~WB_ACK_O) WB_DAT_O <= rd_mux;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      payload_trailer_mode_on <= 1'b0;
      trailer_picker          <= ipcp_pkg::PICK_RST;
      crc_en                  <= 1'b0;
      bytes_per_cycle         <= ipcp_pkg::BPC_RST;
      bpc_reject              <= 1'b0;
    end else begin
      if (wr_mode) payload_trailer_mode_on <= WB_DAT_I[ipcp_pkg::MODE_BIT];
      if (wr_pick) trailer_picker <= WB_DAT_I[ipcp_pkg::PICK_W-1:0];
      if (mode_off_wr) begin
        crc_en <= 1'b0;
      end else if (wr_sw & crc_picked & payload_trailer_mode_on) begin
        crc_en <= WB_DAT_I[ipcp_pkg::SWITCH_BIT];
      end
      if (wr_bpc) begin
        bpc_reject <= ~bpc_ok;
        if (bpc_ok) bytes_per_cycle <= bpc_round;
      end
    end
  end

  // ==========================================================
  // payload assembler: image, other trailers, checksum last
  logic lat_trl;
  logic lat_crc;
  logic in_ready;
  logic in_valid;
  logic [7:0] in_byte;
  logic in_end;
  logic out_valid;
  logic [ipcp_pkg::FIFO_W-1:0] out_word;
  logic sending;

  // trailer choices are frozen at the first pixel of each image
  wire in_idle = (st == ipcp_pkg::ST_IDLE);
  wire in_img  = in_idle | (st == ipcp_pkg::ST_IMG);
  wire eff_trl = in_idle ? (payload_trailer_mode_on & TRL_PRESENT)
                         : lat_trl;
  wire eff_crc = in_idle ? crc_en : lat_crc;
  wire take = in_valid & in_ready;

  always_comb begin
    in_valid = 1'b0;
    in_byte  = 8'h00;
    in_end   = 1'b0;
    next_st  = st;
    case (st)
      ipcp_pkg::ST_IDLE, ipcp_pkg::ST_IMG: begin
        in_valid = PIX_VALID;
        in_byte  = PIX_DATA;
        in_end   = PIX_LAST & ~eff_trl & ~eff_crc;
        if (take) begin
          next_st = !PIX_LAST ? ipcp_pkg::ST_IMG :
                    eff_trl   ? ipcp_pkg::ST_TRL :
                    eff_crc   ? ipcp_pkg::ST_CRC_HI : ipcp_pkg::ST_IDLE;
        end
      end
      ipcp_pkg::ST_TRL: begin
        in_valid = TRL_VALID;
        in_byte  = TRL_DATA;
        in_end   = TRL_LAST & ~lat_crc;
        if (take & TRL_LAST) begin
          next_st = lat_crc ? ipcp_pkg::ST_CRC_HI : ipcp_pkg::ST_IDLE;
        end
      end
      ipcp_pkg::ST_CRC_HI: begin
        in_valid = 1'b1;
        in_byte  = crc[15:8];
        if (take) next_st = ipcp_pkg::ST_CRC_LO;
      end
      ipcp_pkg::ST_CRC_LO: begin
        in_valid = 1'b1;
        in_byte  = crc[7:0];
        in_end   = 1'b1;
        if (take) next_st = ipcp_pkg::ST_IDLE;
      end
      default: next_st = ipcp_pkg::ST_IDLE;
    endcase
  end

  assign PIX_READY = in_ready & in_img;
  assign TRL_READY = in_ready & (st == ipcp_pkg::ST_TRL);

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st      <= ipcp_pkg::ST_IDLE;
      lat_trl <= 1'b0;
      lat_crc <= 1'b0;
      crc     <= ipcp_pkg::CRC_INIT;
    end else begin
      st <= next_st;
      if (in_idle & take) begin
        lat_trl <= eff_trl;
        lat_crc <= eff_crc;
      end
      if (take & (in_img | (st == ipcp_pkg::ST_TRL))) begin
        crc <= crc_byte(in_idle ? ipcp_pkg::CRC_INIT : crc, in_byte);
      end
    end
  end

  ipcp_fifo #(
    .W     (ipcp_pkg::FIFO_W),
    .DEPTH (ipcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .srst      (SRST),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_end, in_byte}),
    .out_valid (out_valid),
    .out_ready (PKT_READY & sending),
    .out_data  (out_word)
  );

  // ==========================================================
  // packet divider, each bus cycle tick arms one start
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic [ipcp_pkg::GAP_W-1:0] gap_cnt;
  logic armed;
  logic [ipcp_pkg::BPC_W-1:0] pkt_cnt;
  logic [ipcp_pkg::BPC_W-1:0] pkt_bpc;

  // ticks closer than half a cycle are glitches, not a new bus cycle
  wire tick = cs_sync & ~cs_prev & (gap_cnt == '0);
  wire pkt_start = armed & out_valid & ~sending;
  wire out_take  = PKT_VALID & PKT_READY;

  assign PKT_VALID   = sending & out_valid;
  assign PKT_DATA    = out_word[7:0];
  assign PKT_IMG_END = out_word[8];
  assign PKT_LAST    = PKT_IMG_END
                     | (pkt_cnt == pkt_bpc - 1'b1);

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cs_meta <= 1'b0;
      cs_sync <= 1'b0;
      cs_prev <= 1'b0;
      gap_cnt <= '0;
      armed   <= 1'b0;
      sending <= 1'b0;
      pkt_cnt <= '0;
      pkt_bpc <= ipcp_pkg::BPC_RST;
    end else begin
      cs_meta <= CYCLE_START;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      if (tick) gap_cnt <= ipcp_pkg::GUARD_CLKS;
      else if (gap_cnt != '0) gap_cnt <= gap_cnt - 1'b1;
      if (tick) armed <= 1'b1;
      else if (pkt_start) armed <= 1'b0;
      if (pkt_start) begin
        sending <= 1'b1;
        pkt_cnt <= '0;
        pkt_bpc <= bytes_per_cycle;
      end else if (out_take) begin
        pkt_cnt <= pkt_cnt + 1'b1;
        if (PKT_LAST) sending <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  property p_crc_needs_mode;
    @(posedge MCLK) disable iff (SRST)
      crc_en |-> payload_trailer_mode_on;
  endproperty
  a_crc_needs_mode: assert property (p_crc_needs_mode)
    else $error("checksum trailer on while trailer mode off");

  property p_mode_off_clears;
    @(posedge MCLK) disable iff (SRST)
      mode_off_wr |=> !crc_en && !payload_trailer_mode_on;
  endproperty
  a_mode_off_clears: assert property (p_mode_off_clears)
    else $error("trailer mode off left a trailer enabled");

  property p_first_crc;
    @(posedge MCLK) disable iff (SRST)
      in_idle && take |=> crc == crc_byte(ipcp_pkg::CRC_INIT,
                                          $past(PIX_DATA));
  endproperty
  a_first_crc: assert property (p_first_crc)
    else $error("checksum does not restart at image start");

  property p_crc_hold;
    @(posedge MCLK) disable iff (SRST)
      st == ipcp_pkg::ST_CRC_HI |=> $stable(crc);
  endproperty
  a_crc_hold: assert property (p_crc_hold)
    else $error("checksum changed while its own bytes go out");

  property p_crc_last;
    @(posedge MCLK) disable iff (SRST)
      st == ipcp_pkg::ST_CRC_LO && take |=>
        st == ipcp_pkg::ST_IDLE && !TRL_READY;
  endproperty
  a_crc_last: assert property (p_crc_last)
    else $error("payload continued after checksum trailer");

  property p_crc_appended;
    @(posedge MCLK) disable iff (SRST)
      in_img && take && PIX_LAST && eff_crc && !eff_trl |=>
        st == ipcp_pkg::ST_CRC_HI;
  endproperty
  a_crc_appended: assert property (p_crc_appended)
    else $error("enabled checksum trailer not appended");

  property p_one_per_cycle;
    @(posedge MCLK) disable iff (SRST)
      pkt_start && !tick |=> !armed;
  endproperty
  a_one_per_cycle: assert property (p_one_per_cycle)
    else $error("second packet started in one bus cycle");

  property p_size_range;
    @(posedge MCLK) disable iff (SRST)
      bytes_per_cycle >= ipcp_pkg::BPC_MIN
      && bytes_per_cycle <= ipcp_pkg::BPC_MAX;
  endproperty
  a_size_range: assert property (p_size_range)
    else $error("packet size left its legal range");

  property p_size_bound;
    @(posedge MCLK) disable iff (SRST)
      sending |-> pkt_cnt < pkt_bpc;
  endproperty
  a_size_bound: assert property (p_size_bound)
    else $error("packet grew past its size setting");

  property p_img_end_closes;
    @(posedge MCLK) disable iff (SRST)
      out_take && PKT_IMG_END |-> PKT_LAST ##1 !sending;
  endproperty
  a_img_end_closes: assert property (p_img_end_closes)
    else $error("image end did not close the packet");

endmodule : ipcp_packetizer

// [tb/ipcp_link_sink.sv]
/*
  Link side stand-in: bus cycle ticks and a sink that stalls at random.
  Assumes the bench seeds $urandom and holds srst high at start.
*/
`timescale 1ns/1ps

// ==========================================================
// link sink
module ipcp_link_sink #(
  parameter int TICK_CLKS = 1250
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pkt_valid,
  output logic      cycle_start,
  output logic      pkt_ready
);
  int cnt;
  int taken;
  always @(posedge clk) begin
    if (srst) begin
      cnt         <= 0;
      taken       <= 0;
      cycle_start <= 1'b0;
      pkt_ready   <= 1'b0;
    end else begin
      cnt         <= (cnt == TICK_CLKS - 1) ? 0 : cnt + 1;
      // a few clocks wide so the pin synchroniser cannot miss it
      cycle_start <= (cnt < 4);
      if (cnt == 0)
        taken <= 0;
      else if (pkt_valid && pkt_ready)
        taken <= taken + 1;
      // the bus carries no more bytes per cycle than its limit
      pkt_ready   <= ($urandom_range(3) != 0) && (taken < 8192);
    end
  end
endmodule : ipcp_link_sink

// [tb/ipcp_packetizer_tb.sv]
/*
  Self-checking bench of the packetizer: register bus, image and
  trailer streams, link payload. Assumes the link sink model.
*/
`timescale 1ns/1ps

// ==========================================================
// bench
module ipcp_packetizer_tb;
  logic        mclk, srst, cyc, stb, we, pv, pl, tp, tv, tl;
  logic [7:0]  adr, pd, td;
  logic [3:0]  sel;
  logic [31:0] wdat;
  wire  [31:0] rdat;
  wire         ack, pr, tr, kv, kr, kl, ke, cs;
  wire  [7:0]  kd;
  int          err_total, total_checks, starts, bcount;
  logic [31:0] rd_exp[$], rd_msk[$];
  logic [8:0]  byte_exp[$];
  int          len_exp[$];

  ipcp_packetizer ipcp_packetizer_inst (.MCLK(mclk), .SRST(srst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .PIX_VALID(pv), .PIX_READY(pr), .PIX_DATA(pd), .PIX_LAST(pl),
    .TRL_PRESENT(tp), .TRL_VALID(tv), .TRL_READY(tr), .TRL_DATA(td),
    .TRL_LAST(tl), .CYCLE_START(cs), .PKT_VALID(kv), .PKT_READY(kr),
    .PKT_DATA(kd), .PKT_LAST(kl), .PKT_IMG_END(ke));

  ipcp_link_sink #(.TICK_CLKS(ipcp_pkg::CYCLE_CLKS)) ipcp_link_sink_inst (
    .clk(mclk), .srst(srst), .pkt_valid(kv), .cycle_start(cs),
    .pkt_ready(kr));

  task automatic results;
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic timeout(input string n);
    $display("ERROR %s expected done seen timeout", n);
    err_total++;
    results();
  endtask : timeout

  // ========================================================
  // watchers: sample at the falling edge, where all is settled
  always @(negedge mclk) begin
    if (ack && !we)
      chk("register read", rd_exp.pop_front(),
          rdat & rd_msk.pop_front());
    if (kv && kr) begin
      if (bcount == 0)
        starts++;
      bcount++;
      chk("one start per cycle", 32'h1, 32'(starts <= 1));
      chk("link byte", 32'(byte_exp.size() ? byte_exp.pop_front() : 9'h1FF),
          {23'h0, ke, kd});
      if (kl) begin
        chk("packet length", len_exp.pop_front(), bcount);
        bcount = 0;
      end
    end
  end
  always @(posedge cs)
    starts = 0;

  // ========================================================
  // drivers
  task automatic wb(input bit w, input logic [7:0] a, input logic [31:0] d);
    logic got;
    int   k;
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    got = 1'b0;
    for (k = 0; k < 100 && !got; k++) begin
      @(negedge mclk);
      got = ack;
      @(posedge mclk);
    end
    if (!got)
      timeout("bus ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    rd_exp.push_back(e);
    rd_msk.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask : rd

  task automatic send(input bit t, input logic [7:0] d, input bit l);
    logic rdy;
    int   k;
    @(posedge mclk);
    if (t) begin
      tv <= 1'b1;
      td <= d;
      tl <= l;
    end else begin
      pv <= 1'b1;
      pd <= d;
      pl <= l;
    end
    rdy = 1'b0;
    for (k = 0; k < 5000 && !rdy; k++) begin
      @(negedge mclk);
      rdy = t ? tr : pr;
      @(posedge mclk);
    end
    if (!rdy)
      timeout("stream ready");
    tv <= 1'b0;
    pv <= 1'b0;
  endtask : send

  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (b[i]) begin
      c = c ^ {b[i], 8'h00};
      repeat (8)
        c = c[15] ? ((c << 1) ^ ipcp_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc

  // one image of n bytes, plus nt trailer bytes and the checksum only when on, size setting 8
  task automatic image(input int n, input int nt, input bit on);
    logic [7:0]  b[$], pay[$];
    logic [15:0] c;
    int          p, k;
    for (k = 0; k < n + nt; k++)
      b.push_back(8'($urandom));
    pay = on ? b : b[0:n-1];
    if (on) begin
      c = crc(pay);
      pay.push_back(c[15:8]);
      pay.push_back(c[7:0]);
    end
    foreach (pay[i])
      byte_exp.push_back({1'(i == pay.size() - 1), pay[i]});
    for (p = pay.size(); p > 8; p -= 8)
      len_exp.push_back(8);
    len_exp.push_back(p);
    tp <= (nt > 0);
    for (k = 0; k < n; k++)
      send(1'b0, b[k], k == n - 1);
    for (k = 0; on && k < nt; k++)
      send(1'b1, b[n+k], k == nt - 1);
    for (k = 0; k < 40000 && byte_exp.size(); k++)
      @(posedge mclk);
    if (byte_exp.size())
      timeout("image drain");
    tp <= 1'b0;
  endtask : image

  // ========================================================
  // main sequence
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    {srst, cyc, stb, we, pv, pl, tp, tv, tl} = 9'h100;
    {adr, pd, td, sel, wdat} = '0;
    err_total = 0;
    total_checks = 0;
    starts = 0;
    bcount = 0;
    void'($urandom(32'h254D));
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    rd(ipcp_pkg::REG_BPC, 32'h2000, 32'h3FFF);
    rd(ipcp_pkg::REG_MODE, 32'h0, 32'h1);
    wb(1'b1, ipcp_pkg::REG_PICK, 32'h1);
    wb(1'b1, ipcp_pkg::REG_SWITCH, 32'h1);
    rd(ipcp_pkg::REG_SWITCH, 32'h0, 32'h1);
    wb(1'b1, ipcp_pkg::REG_BPC, 32'h0);
    rd(ipcp_pkg::REG_STAT, 32'h20000, 32'h20000);
    wb(1'b1, ipcp_pkg::REG_BPC, 32'h2001);
    rd(ipcp_pkg::REG_BPC, 32'h2000, 32'h3FFF);
    wb(1'b1, ipcp_pkg::REG_BPC, 32'hA);
    rd(ipcp_pkg::REG_BPC, 32'h8, 32'h3FFF);
    rd(ipcp_pkg::REG_STAT, 32'h0, 32'h20000);
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);
    wb(1'b1, ipcp_pkg::REG_MODE, 32'h1);
    wb(1'b1, ipcp_pkg::REG_SWITCH, 32'h1);
    rd(ipcp_pkg::REG_SWITCH, 32'h1, 32'h1);
    image(37, 5, 1'b1);
    image(14, 0, 1'b1);
    wb(1'b1, ipcp_pkg::REG_MODE, 32'h0);
    rd(ipcp_pkg::REG_SWITCH, 32'h0, 32'h1);
    image(21, 4, 1'b0);
    results();
  end
endmodule : ipcp_packetizer_tb
